// >>> epf_pwm.sv
// Purpose: Two-channel edge-aligned PWM with fault protection
// Assumes: Inputs synchronous to sys_clk except the fault pins
// Notes:   Summary of operation below
// Summary of operation
// - Positive polarity drives output high when active
// - Disabled channel forced inactive, generator keeps running
// - Fault interrupt output separate from reload interrupt
// - Fault disables only channels with map set
// - Recovery mode bit selects automatic or manual
// - Mapped fault disables outputs combinationally, at once
// - Fault pin selectable, pins stay shared
// - Auto: re-enable after fault low, new cycle
// - Auto: flag clearing does not re-enable outputs
// - Pin-state bit always shows fault level
// - Rising fault edge sets flag; write-1 clears
// - Fault irq latch: set, ack, enable clear
// - Manual: flag cleared and fault low at cycle
// - Soft disable immediate, released at new cycle
// - Enable: immediate reload, flag, irq, drive pins
// - Fresh enable uses zero values, last modulus
// - Disable: tristate, counter cleared, generator zero
// - Wait mode: clocks run, interrupts wake
// - Stop mode: freeze, outputs zero, keep state
// - High byte read latches counter low byte
// - Buffered 12-bit modulus, not reset
// - Zero modulus counts down from maximum
// - Polarity bit one is positive
// - Map bit one lets fault disable channel
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module epf_pwm
  import epf_pkg::*;
#(
  parameter int CNT_W = 12
)(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdData,
  input  wire logic       faultPinA,
  input  wire logic       faultPinB,
  input  wire logic       stopMode,
  output epf_pins_s       pins,
  output logic            faultIrq,
  output logic            reloadIrq,
  output logic            wakeReq
);
  // Elaboration check: the register map only serves 12 bits
  if (CNT_W != 12)
  begin
    $error("Counter width must be 12");
  end

  // ******************************************************
  // State
  // ******************************************************
  typedef struct packed {
    logic [2:0]  presc;
    logic [11:0] cnt;
    logic [2:0]  cycCnt;
    logic        en;
    logic        load_okay;
    logic        rflag;
    logic        rArm;
    logic        rien;
    logic        fpos;
    logic [1:0]  dis;
    logic [1:0]  pol;
    logic [1:0]  prscBuf;
    logic [1:0]  prscAct;
    logic [1:0]  ldfqBuf;
    logic [1:0]  ldfqAct;
    logic [1:0]  map;
    logic        mapLocked;
    logic        fauto;
    logic        fien;
    logic        fault_event_flag;
    logic        firq;
    logic        fSync1;
    logic        fSync2;
    logic        fPrev;
    logic [1:0]  faultLat;
    logic [1:0]  swLat;
    logic [15:0] val0Buf;
    logic [15:0] val1Buf;
    logic [11:0] val0Act;
    logic [11:0] val1Act;
    logic [7:0]  cntLo;
    logic        loHeld;
    logic [7:0]  rdData;
    logic [1:0]  level;
    logic [1:0]  oeN;
    logic        stopped;
    logic        faultIrqOut;
    logic        reloadIrqOut;
    logic        wakeOut;
  } epf_state_s;

  epf_state_s s_q;
  epf_state_s s_d;
  // Modulus has no reset: zero is legal and counts down from maximum, so none is forced
  logic [11:0] modBuf_q;
  logic [11:0] modBuf_d;
  logic [11:0] modAct_q;
  logic [11:0] modAct_d;

  // ******************************************************
  // Helpers
  // ******************************************************
  function automatic logic [2:0] powMask(input logic [1:0] sel);
    unique case (sel)
      2'h0: powMask = 3'h0;
      2'h1: powMask = 3'h1;
      2'h2: powMask = 3'h3;
      2'h3: powMask = 3'h7;
    endcase
  endfunction

  // Clamp signed 16-bit duty value to the 12-bit range
  function automatic logic [11:0] clampVal(input logic [15:0] v);
    if (v[15])
      clampVal = CNT_RESET;
    else if (v[14:12] != 3'h0)
      clampVal = VAL_MAX;
    else
      clampVal = v[11:0];
  endfunction

  logic       faultRaw;
  logic [1:0] chOff;

  assign faultRaw = s_q.fpos ? faultPinA : faultPinB;

  // ******************************************************
  // Next state
  // ******************************************************
  logic        tick;
  logic        cycEnd;
  logic        reload;
  logic        fRise;
  logic        wr;
  logic [11:0] vAct [2];

  always_comb
  begin
    s_d      = s_q;
    modBuf_d = modBuf_q;
    modAct_d = modAct_q;
    wr       = regWr && !regRd;
    vAct[0]  = s_q.val0Act;
    vAct[1]  = s_q.val1Act;
    s_d.stopped = stopMode;
    // Synchroniser; only the second stage feeds the edge detect
    s_d.fSync1 = faultRaw;
    s_d.fSync2 = s_q.fSync1;
    s_d.fPrev  = s_q.fSync2;
    fRise  = s_q.fSync2 && !s_q.fPrev;
    tick   = s_q.en && !stopMode && s_q.presc == powMask(s_q.prscAct);
    if (modAct_q == 12'h000)
      cycEnd = tick && s_q.cnt == 12'h000;
    else
      cycEnd = tick && s_q.cnt >= modAct_q;
    reload = cycEnd && s_q.cycCnt == powMask(s_q.ldfqAct);

    // Counter and prescaler; frozen in stop mode
    if (!s_q.en)
    begin
      s_d.presc  = 3'h0;
      s_d.cnt    = CNT_RESET;
      s_d.cycCnt = 3'h0;
    end
    else if (!stopMode)
    begin
      s_d.presc = tick ? 3'h0 : s_q.presc + 3'h1;
      if (tick)
      begin
        if (modAct_q == 12'h000)
          s_d.cnt = s_q.cnt - 12'h001;
        else
          s_d.cnt = cycEnd ? 12'h001 : s_q.cnt + 12'h001;
      end
      if (cycEnd)
        s_d.cycCnt = reload ? 3'h0 : s_q.cycCnt + 3'h1;
    end

    // Bus writes
    if (wr)
    begin
      unique case (regAddr)
        CTRL1_OFS:
        begin
          s_d.en   = regWrData[EN_BIT];
          s_d.load_okay = regWrData[LOAD_OKAY_BIT];
          s_d.rien = regWrData[RIEN_BIT];
          s_d.fpos = regWrData[FPOS_BIT];
          if (!regWrData[RFLAG_BIT] && s_q.rArm)
            s_d.rflag = 1'b0;
        end
        CTRL2_OFS:
        begin
          s_d.dis     = regWrData[DIS_LSB+:2];
          s_d.pol     = regWrData[POL_LSB+:2];
          s_d.prscBuf = regWrData[PRSC_LSB+:2];
          s_d.ldfqBuf = regWrData[RELOAD_INTERVAL_SEL_LSB+:2];
        end
        DISMAP_OFS:
          if (!s_q.mapLocked)
          begin
            s_d.map       = regWrData[1:0];
            s_d.mapLocked = 1'b1;
          end
        FAULTCTL_OFS:
        begin
          s_d.fauto = regWrData[FAUTO_BIT];
          s_d.fien  = regWrData[FIEN_BIT];
          if (regWrData[FACK_BIT])
          begin
            s_d.fault_event_flag = 1'b0;
            s_d.firq  = 1'b0;
          end
        end
        MOD_HI_OFS:   modBuf_d[11:8] = regWrData[3:0];
        MOD_LO_OFS:   modBuf_d[7:0]  = regWrData;
        VAL0_HI_OFS:  s_d.val0Buf[15:8] = regWrData;
        VAL0_LO_OFS:  s_d.val0Buf[7:0]  = regWrData;
        VAL1_HI_OFS:  s_d.val1Buf[15:8] = regWrData;
        VAL1_LO_OFS:  s_d.val1Buf[7:0]  = regWrData;
        default:      ;
      endcase
    end
    if (!s_d.fien)
      s_d.firq = 1'b0;

    // Reload: on cycle boundary or enable going high
    if (reload || (s_d.en && !s_q.en))
    begin
      s_d.rflag   = 1'b1;
      s_d.rArm    = 1'b0;
      s_d.ldfqAct = s_q.ldfqBuf;
      if (s_q.load_okay)
      begin
        modAct_d    = modBuf_q;
        s_d.prscAct = s_q.prscBuf;
        s_d.val0Act = clampVal(s_q.val0Buf);
        s_d.val1Act = clampVal(s_q.val1Buf);
        s_d.load_okay    = 1'b0;
      end
    end
    else if (regRd && regAddr == CTRL1_OFS && s_q.rflag)
      s_d.rArm = 1'b1;

    // Fault event flag; set wins over the acknowledge
    if (fRise)
    begin
      s_d.fault_event_flag = 1'b1;
      if (s_d.fien)
        s_d.firq = 1'b1;
    end

    // Disable latches, released only at a new cycle
    for (int i = 0; i < 2; i++)
    begin
      if (s_q.fSync2 && s_q.map[i])
        s_d.faultLat[i] = 1'b1;
      else if (cycEnd && !s_q.fSync2)
      begin
        if (s_q.fauto || !s_q.fault_event_flag)
          s_d.faultLat[i] = 1'b0;
      end
      if (s_q.dis[i])
        s_d.swLat[i] = 1'b1;
      else if (cycEnd)
        s_d.swLat[i] = 1'b0;
      // Generator output; forced to zero while disabled
      if (!s_d.en)
        s_d.level[i] = 1'b0;
      else if (!stopMode)
        s_d.level[i] = s_d.cnt != 12'h000
                       && s_d.cnt <= vAct[i];
      s_d.oeN[i] = !s_d.en;
    end

    // Counter read latching
    if (regRd && regAddr == CNT_HI_OFS)
    begin
      s_d.cntLo  = s_q.cnt[7:0];
      s_d.loHeld = 1'b1;
    end
    else if (regRd && regAddr == CNT_LO_OFS)
      s_d.loHeld = 1'b0;

    // Read data stands one cycle only
    s_d.rdData = RD_IDLE;
    if (regRd)
    begin
      unique case (regAddr)
        CTRL1_OFS:
        begin
          s_d.rdData[EN_BIT]    = s_q.en;
          s_d.rdData[LOAD_OKAY_BIT]  = s_q.load_okay;
          s_d.rdData[RFLAG_BIT] = s_q.rflag;
          s_d.rdData[RIEN_BIT]  = s_q.rien;
          s_d.rdData[FPOS_BIT]  = s_q.fpos;
        end
        CTRL2_OFS:
          s_d.rdData = {s_q.ldfqBuf, s_q.prscBuf, s_q.pol, s_q.dis};
        DISMAP_OFS:   s_d.rdData = {6'h00, s_q.map};
        FAULTCTL_OFS:
        begin
          s_d.rdData[FAUTO_BIT] = s_q.fauto;
          s_d.rdData[FIEN_BIT]  = s_q.fien;
          s_d.rdData[FAULT_EVENT_FLAG_BIT] = s_q.fault_event_flag;
          s_d.rdData[FAULT_PIN_STATE_BIT]  = s_q.fSync2;
        end
        CNT_HI_OFS:   s_d.rdData = {4'h0, s_q.cnt[11:8]};
        CNT_LO_OFS:
          s_d.rdData = s_q.loHeld ? s_q.cntLo : s_q.cnt[7:0];
        MOD_HI_OFS:   s_d.rdData = {4'h0, modBuf_q[11:8]};
        MOD_LO_OFS:   s_d.rdData = modBuf_q[7:0];
        VAL0_HI_OFS:  s_d.rdData = s_q.val0Buf[15:8];
        VAL0_LO_OFS:  s_d.rdData = s_q.val0Buf[7:0];
        VAL1_HI_OFS:  s_d.rdData = s_q.val1Buf[15:8];
        VAL1_LO_OFS:  s_d.rdData = s_q.val1Buf[7:0];
        default:      s_d.rdData = RD_IDLE;
      endcase
    end

    // Interrupt outputs; disable keeps pending requests
    s_d.faultIrqOut  = s_d.firq;
    s_d.reloadIrqOut = s_d.rflag && s_d.rien;
    s_d.wakeOut      = s_d.firq || (s_d.rflag && s_d.rien);
  end

  // ******************************************************
  // Registers
  // ******************************************************
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q     <= '0;
      s_q.oeN <= 2'h3;
    end
    else
      s_q <= s_d;
  end

  always_ff @(posedge sys_clk)
  begin
    modBuf_q <= modBuf_d;
    modAct_q <= modAct_d;
  end

  // ******************************************************
  // Outputs
  // ******************************************************
  // Fault gating is combinational so a trip never waits a clock
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      chOff[i] = s_q.swLat[i] || s_q.dis[i] || s_q.faultLat[i]
                 || (faultRaw && s_q.map[i]);
      if (s_q.stopped)
        pins.level[i] = 1'b0;
      else if (chOff[i])
        pins.level[i] = !s_q.pol[i];
      else
        pins.level[i] = s_q.pol[i] ? s_q.level[i]
                                   : !s_q.level[i];
    end
    pins.oeN = s_q.oeN;
  end

  assign regRdData = s_q.rdData;
  assign faultIrq  = s_q.faultIrqOut;
  assign reloadIrq = s_q.reloadIrqOut;
  assign wakeReq   = s_q.wakeOut;
endmodule

// >>> epf_pkg.sv
// Purpose: Shared constants and types for the two-channel PWM block
// Assumes: Byte-wide register port, 4-bit register index
// Notes:   Offsets are register indices on the plain port
package epf_pkg;
  // ******************************************************
  // Register indices
  // ******************************************************
  localparam logic [3:0] CTRL1_OFS     = 4'h0;
  localparam logic [3:0] CTRL2_OFS     = 4'h1;
  localparam logic [3:0] DISMAP_OFS    = 4'h2;
  localparam logic [3:0] FAULTCTL_OFS  = 4'h3;
  localparam logic [3:0] CNT_HI_OFS    = 4'h4;
  localparam logic [3:0] CNT_LO_OFS    = 4'h5;
  localparam logic [3:0] MOD_HI_OFS    = 4'h6;
  localparam logic [3:0] MOD_LO_OFS    = 4'h7;
  localparam logic [3:0] VAL0_HI_OFS   = 4'h8;
  localparam logic [3:0] VAL0_LO_OFS   = 4'h9;
  localparam logic [3:0] VAL1_HI_OFS   = 4'ha;
  localparam logic [3:0] VAL1_LO_OFS   = 4'hb;
  // ******************************************************
  // Field positions
  // ******************************************************
  localparam int EN_BIT     = 0;  // CTRL1 module_enable
  localparam int LOAD_OKAY_BIT   = 1;  // CTRL1 load_okay
  localparam int RFLAG_BIT  = 4;  // CTRL1 reload_flag
  localparam int RIEN_BIT   = 5;  // CTRL1 reload_irq_enable
  localparam int FPOS_BIT   = 6;  // CTRL1 fault pin select, 1 = pin A
  localparam int DIS_LSB    = 0;  // CTRL2 soft_disable_ch1:ch0
  localparam int POL_LSB    = 2;  // CTRL2 channel_polarity_sel
  localparam int PRSC_LSB   = 4;  // CTRL2 prescaler
  localparam int RELOAD_INTERVAL_SEL_LSB   = 6;  // CTRL2 reload_interval_sel
  localparam int FAUTO_BIT  = 0;  // FAULTCTL fault_recovery_auto
  localparam int FIEN_BIT   = 1;  // FAULTCTL fault_irq_enable
  localparam int FAULT_EVENT_FLAG_BIT  = 2;  // FAULTCTL fault_event_flag
  localparam int FAULT_PIN_STATE_BIT   = 3;  // FAULTCTL fault_pin_state
  localparam int FACK_BIT   = 4;  // FAULTCTL fault_acknowledge
  // ******************************************************
  // Reset and limit values
  // ******************************************************
  localparam logic [11:0] CNT_RESET = 12'h000;
  localparam logic [11:0] VAL_MAX   = 12'hfff;
  localparam logic [7:0]  RD_IDLE   = 8'h00;

  typedef struct packed {
    logic [1:0] level;    // Pin levels
    logic [1:0] oeN;      // Low while the pin is driven
  } epf_pins_s;
endpackage

// >>> epf_pwm_props.sv
// Purpose: Port-level checks for the PWM block
// Assumes: Register writes shadowed from the plain port
// Notes:   Fault flag path allows a synchroniser delay
`timescale 1ns/1ps
module epf_pwm_props
  import epf_pkg::*;
#(
  parameter int CNT_W = 12
)(
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic [7:0] regRdData,
  input wire logic       faultPinA,
  input wire logic       faultPinB,
  input wire logic       stopMode,
  input wire epf_pins_s  pins,
  input wire logic       faultIrq,
  input wire logic       reloadIrq,
  input wire logic       wakeReq
);
  // ****************************************************
  // Register shadows
  // ****************************************************
  logic       modEn_q, fpos_q, fien_q, rien_q, mapSet_q;
  logic [1:0] dis_q, pol_q, map_q;
  logic [2:0] sync_q;
  logic       wrOk, ackWr, faultSel;
  assign wrOk     = regWr && !regRd;
  assign ackWr    = wrOk && regAddr == FAULTCTL_OFS && regWrData[FACK_BIT];
  assign faultSel = fpos_q ? faultPinA : faultPinB;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {modEn_q, fpos_q, fien_q, rien_q, mapSet_q} <= 5'h00;
      {dis_q, pol_q, map_q, sync_q} <= 9'h000;
    end
    else
    begin
      sync_q <= {sync_q[1:0], faultSel};
      if (wrOk && regAddr == CTRL1_OFS)
        {fpos_q, rien_q, modEn_q} <= {regWrData[FPOS_BIT],
          regWrData[RIEN_BIT], regWrData[EN_BIT]};
      if (wrOk && regAddr == CTRL2_OFS)
        {pol_q, dis_q} <= regWrData[3:0];
      if (wrOk && regAddr == FAULTCTL_OFS)
        fien_q <= regWrData[FIEN_BIT];
      // Map is write-once until reset
      if (wrOk && regAddr == DISMAP_OFS && !mapSet_q)
        {mapSet_q, map_q} <= {1'b1, regWrData[1:0]};
    end
  end
  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence sArmedRise;
    $rose(faultSel) ##0 (fien_q && !ackWr) [*4];
  endsequence
  sequence sQuiet;
    !faultSel && sync_q == 3'b000;
  endsequence
  // Stop is registered in the block, so pins fall one cycle later
  a_stop_pins_low: assert property ($past(stopMode)
    && modEn_q && stopMode |-> pins.level == 2'b00)
    else $error("pins not low in stop mode");
  a_wake_on_irq: assert property ($rose(faultIrq) |-> ##[0:1] wakeReq)
    else $error("no wake request on fault interrupt");
  a_fault_forces_off: assert property (modEn_q && faultSel && !stopMode
    && $stable(pol_q) |-> (pins.level & map_q) == (~pol_q & map_q))
    else $error("mapped channel not inactive during fault");
  a_soft_forces_off: assert property (modEn_q && !stopMode && $stable(pol_q)
    |-> (pins.level & dis_q) == (~pol_q & dis_q))
    else $error("soft disabled channel not inactive");
  a_off_tristate: assert property (!modEn_q && !$past(modEn_q)
    |-> pins.oeN == 2'b11)
    else $error("pins driven while module disabled");
  a_on_drives: assert property (modEn_q && $past(modEn_q)
    |-> pins.oeN == 2'b00)
    else $error("pins not driven while module enabled");
  a_fault_irq_set: assert property (sArmedRise |-> faultIrq)
    else $error("fault interrupt not latched");
  a_ack_drops_irq: assert property (ackWr ##0 sQuiet |-> ##[1:2] !faultIrq)
    else $error("fault interrupt kept after acknowledge");
  a_fien_drops_irq: assert property ($fell(fien_q) |-> ##[0:1] !faultIrq)
    else $error("fault interrupt kept after enable cleared");
  a_irq_separate: assert property (!rien_q && !$past(rien_q) |-> !reloadIrq)
    else $error("reload interrupt raised while disabled");
endmodule

bind epf_pwm epf_pwm_props #(.CNT_W(CNT_W)) u_props (.sys_clk(sys_clk),
  .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
  .regRd(regRd), .regRdData(regRdData), .faultPinA(faultPinA),
  .faultPinB(faultPinB), .stopMode(stopMode), .pins(pins),
  .faultIrq(faultIrq), .reloadIrq(reloadIrq), .wakeReq(wakeReq));

// >>> epf_drive_model.sv
// Purpose: Fault source of the external drive stage
// Assumes: Trip request sampled on sys_clk
// Notes:   Line moves off the clock edge to reach the async path
`timescale 1ns/1ps
module epf_drive_model (
  input  wire logic       sys_clk,
  input  wire logic       tripReq,
  input  wire logic [7:0] holdLen,
  output logic            faultLine
);
  always
  begin
    faultLine = 1'b0;
    @(posedge sys_clk iff tripReq);
    #17 faultLine = 1'b1;
    repeat (holdLen) @(posedge sys_clk);
    #13;
  end
endmodule

// >>> epf_pwm_tb.sv
// Purpose: Self-checking bench for the two-channel PWM block
// Assumes: Modulus below 256, prescaler and reload interval zero
// Notes:   Channel 0 always active, channel 1 never active
`timescale 1ns/1ps
module epf_pwm_tb
  import epf_pkg::*;
;
  logic       sys_clk, rst_n, regWr, regRd, faultPinA, faultPinB;
  logic       stopMode, tripReq, noiseOn, faultIrq, reloadIrq, wakeReq;
  logic [3:0] regAddr;
  logic [7:0] regWrData, regRdData, holdLen, rd8, rnd, modV, cntLo;
  logic [1:0] polV;
  epf_pins_s  pins;
  int         fail_count, cmp_count;

  epf_pwm dut (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .faultPinA(faultPinA), .faultPinB(faultPinB),
    .stopMode(stopMode), .pins(pins), .faultIrq(faultIrq),
    .reloadIrq(reloadIrq), .wakeReq(wakeReq));
  epf_drive_model drv (.sys_clk(sys_clk), .tripReq(tripReq),
    .holdLen(holdLen), .faultLine(faultPinA));

  always #25 sys_clk = ~sys_clk;
  // Unselected fault pin chatters to prove it is ignored
  always @(posedge sys_clk) faultPinB <= noiseOn ? 1'($urandom) : 1'b0;

  // ****************************************************
  // Bus and check tasks
  // ****************************************************
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    @(negedge sys_clk);
    d = regRdData;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      fail_count++;
    end
  endtask
  task automatic rdChk(input logic [3:0] a, input logic [7:0] exp);
    rd(a, rd8);
    chk(rd8, exp);
  endtask
  task automatic waitCyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic trip(input logic [7:0] n);
    @(posedge sys_clk);
    holdLen <= n;
    tripReq <= 1'b1;
    @(posedge faultPinA);
    tripReq = 1'b0;
    #1;
  endtask
  // Expected pin byte: channel 0 active, channel 1 inactive
  function automatic logic [7:0] lvl(input logic [1:0] off);
    return {6'h00, ~((2'b01 & ~off) ^ polV)};
  endfunction
  task automatic conclude();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    conclude();
  end

  // ****************************************************
  // Test sequence
  // ****************************************************
  initial
  begin
    {sys_clk, rst_n, regWr, regRd, stopMode} = 5'h00;
    {tripReq, noiseOn, regAddr, regWrData, holdLen} = 22'h000000;
    fail_count = 0;
    cmp_count  = 0;
    void'($urandom(66141));
    modV = 8'h08 + 8'($urandom % 32);
    rnd  = 8'($urandom);
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    rdChk(FAULTCTL_OFS, 8'h00);
    wr(MOD_HI_OFS, rnd);
    rdChk(MOD_HI_OFS, rnd & 8'h0f);
    wr(4'hd, rnd);
    rdChk(4'hd, 8'h00);
    wr(MOD_HI_OFS, 8'h00);
    wr(MOD_LO_OFS, modV);
    rdChk(MOD_LO_OFS, modV);
    wr(VAL0_HI_OFS, 8'h0f);
    wr(VAL0_LO_OFS, 8'hff);
    wr(DISMAP_OFS, 8'h01);
    wr(DISMAP_OFS, 8'h03);
    rdChk(DISMAP_OFS, 8'h01);
    wr(FAULTCTL_OFS, 8'h03);
    wr(CTRL1_OFS, 8'h42);
    wr(CTRL1_OFS, 8'h43);
    noiseOn = 1'b1;
    waitCyc(2);
    chk({6'h00, pins.oeN}, 8'h00);
    rd(CTRL1_OFS, rd8);
    chk({7'h00, rd8[RFLAG_BIT]}, 8'h01);
    for (int p = 0; p < 4; p++)
    begin
      polV = 2'(p);
      wr(CTRL2_OFS, {4'h0, polV, 2'b00});
      waitCyc(2);
      chk({6'h00, pins.level}, lvl(2'b00));
    end
    polV = 2'($urandom);
    wr(CTRL2_OFS, {4'h0, polV, 2'b00});
    $display("done: setup and polarity");
    trip(8'd30);
    chk({6'h00, pins.level}, lvl(2'b01));
    waitCyc(5);
    chk({5'h00, reloadIrq, faultIrq, wakeReq}, 8'h03);
    rdChk(FAULTCTL_OFS, 8'h0f);
    wr(FAULTCTL_OFS, 8'h13);
    rdChk(FAULTCTL_OFS, 8'h0b);
    chk({6'h00, pins.level}, lvl(2'b01));
    @(negedge faultPinA);
    waitCyc(int'(modV) + 3);
    chk({6'h00, pins.level}, lvl(2'b00));
    $display("done: automatic recovery");
    wr(FAULTCTL_OFS, 8'h02);
    trip(8'd4);
    @(negedge faultPinA);
    waitCyc(int'(modV) + 3);
    chk({6'h00, pins.level}, lvl(2'b01));
    rdChk(FAULTCTL_OFS, 8'h06);
    wr(FAULTCTL_OFS, 8'h12);
    waitCyc(int'(modV) + 3);
    chk({5'h00, faultIrq, pins.level}, lvl(2'b00));
    trip(8'd4);
    waitCyc(6);
    wr(FAULTCTL_OFS, 8'h00);
    waitCyc(1);
    chk({7'h00, faultIrq}, 8'h00);
    rdChk(FAULTCTL_OFS, 8'h04);
    wr(FAULTCTL_OFS, 8'h10);
    $display("done: manual recovery");
    wr(CTRL2_OFS, {4'h0, polV, 2'b01});
    waitCyc(1);
    chk({5'h00, faultIrq, pins.level}, lvl(2'b01));
    wr(CTRL2_OFS, {4'h0, polV, 2'b00});
    waitCyc(int'(modV) + 3);
    chk({6'h00, pins.level}, lvl(2'b00));
    $display("done: soft disable");
    @(posedge sys_clk);
    stopMode <= 1'b1;
    waitCyc(1);
    chk({6'h00, pins.level}, 8'h00);
    rd(CNT_LO_OFS, cntLo);
    rdChk(CNT_HI_OFS, 8'h00);
    @(posedge sys_clk);
    stopMode <= 1'b0;
    waitCyc(3);
    @(posedge sys_clk);
    stopMode <= 1'b1;
    rdChk(CNT_LO_OFS, cntLo);
    rd(CNT_LO_OFS, rd8);
    chk({7'h00, rd8 === cntLo}, 8'h00);
    @(posedge sys_clk);
    stopMode <= 1'b0;
    $display("done: stop and counter latch");
    wr(CTRL1_OFS, 8'h61);
    waitCyc(1);
    chk({6'h00, reloadIrq, wakeReq}, 8'h03);
    // Disable with the reload request pending; it must survive
    wr(CTRL1_OFS, 8'h60);
    waitCyc(2);
    chk({6'h00, pins.oeN}, 8'h03);
    chk({7'h00, reloadIrq}, 8'h01);
    rd(CTRL1_OFS, rd8);
    chk({7'h00, rd8[RFLAG_BIT]}, 8'h01);
    rdChk(CNT_HI_OFS, 8'h00);
    rdChk(CNT_LO_OFS, 8'h00);
    trip(8'd3);
    waitCyc(5);
    rdChk(FAULTCTL_OFS, 8'h04);
    wr(FAULTCTL_OFS, 8'h10);
    $display("done: module disable");
    conclude();
  end
endmodule
